// file: adcrt_top.sv
// adcrt_top.sv - conversion control, busy flag, result buffer, parallel and serial readout
// assumes pins arrive asynchronously; sar_result comes from the core on this clock
`timescale 1ns/1ps
`include "adcrt_consts.svh"
module adcrt_top
	import adcrt_pkg::*;
(
	// clock, reset and freeze
	input  wire logic        clock,
	input  wire logic        rst_n,
	input  wire logic        clk_en,
	// host pins
	input  wire logic        convert_start_n,
	input  wire logic        dev_reset,
	input  wire logic        chip_select_n,
	input  wire logic        bus_req_n,
	input  wire logic [1:0]  mode,
	input  wire logic [1:0]  serial_clock_divider,
	// conversion core
	input  wire adcrt_word_t sar_result,
	// status and parallel port
	output logic             busy,
	output adcrt_word_t      par_data,
	output logic             par_oe_n,
	// serial master port
	output adcrt_ser_t       serial_port
);
	localparam int         PW       = $bits(adcrt_pins_t);
	localparam int         W        = `ADCRT_RES_W;
	localparam logic [PW-1:0] PIN_RST = `ADCRT_PIN_RST;
	localparam logic [6:0] CONV_END = 7'(`ADCRT_BUSY_CYC - `ADCRT_EOC_GAP_CYC - 2);
	localparam logic [6:0] RST_END  = 7'(`ADCRT_RST_BUSY_CYC - `ADCRT_BUSY_RISE_CYC);
	localparam logic [4:0] RDC_END  = 5'(`ADCRT_SYNC_RDC_CYC - 2);
	localparam logic [4:0] BIT_END  = 5'(W - 1);

	// two-stage synchronisers for every pin bit
	logic          sync0_r [PW];
	logic          sync1_r [PW];
	logic [PW-1:0] pin_raw;
	logic [PW-1:0] pin_vec;
	adcrt_pins_t   pin_s;
	assign pin_raw = {dev_reset, convert_start_n, chip_select_n, bus_req_n, mode,
		serial_clock_divider};
	assign pin_s   = adcrt_pins_t'(pin_vec);
	generate
		for (genvar i = 0; i < PW; i++) begin : g_sync
			always_ff @(posedge clock) begin
				if (!rst_n) begin
					sync0_r[i] <= PIN_RST[i];
					sync1_r[i] <= PIN_RST[i];
				end else if (clk_en) begin
					sync0_r[i] <= pin_raw[i];
					sync1_r[i] <= sync0_r[i];
				end
			end
			assign pin_vec[i] = sync1_r[i];
		end
	endgenerate

	// state of control, buffer and readout
	adcrt_ctl_t  ctl_r, ctl_nxt;
	logic [6:0]  cnt_r, cnt_nxt;
	logic        busy_r, busy_nxt;
	adcrt_pins_t prev_r, prev_nxt;
	adcrt_word_t buf_r [2];
	adcrt_word_t buf_nxt [2];
	logic        wp_r, wp_nxt;
	logic        rp_r, rp_nxt;
	logic [1:0]  fill_r, fill_nxt;
	adcrt_word_t par_data_r, par_data_nxt;
	logic        par_oe_n_r, par_oe_n_nxt;
	adcrt_srst_t ser_st_r, ser_st_nxt;
	logic [4:0]  scnt_r, scnt_nxt;
	logic [2:0]  hcnt_r, hcnt_nxt;
	adcrt_word_t shreg_r, shreg_nxt;
	adcrt_ser_t  ser_r, ser_nxt;
	// decoded events
	logic        start_fall;
	logic        start_ok;
	logic        rst_fall;
	logic        push;
	logic        pop;
	logic        ser_go;
	logic        rac_go;
	adcrt_word_t head;
	adcrt_word_t ser_src;

	assign busy        = busy_r;
	assign par_data    = par_data_r;
	assign par_oe_n    = par_oe_n_r;
	assign serial_port = ser_r;
	assign head        = buf_r[rp_r];

	// next-state logic of the whole block
	always_comb begin
		ctl_nxt      = ctl_r;
		cnt_nxt      = cnt_r;
		busy_nxt     = busy_r;
		prev_nxt     = pin_s;
		buf_nxt      = buf_r;
		wp_nxt       = wp_r;
		rp_nxt       = rp_r;
		par_data_nxt = par_data_r;
		ser_st_nxt   = ser_st_r;
		scnt_nxt     = scnt_r;
		hcnt_nxt     = hcnt_r;
		shreg_nxt    = shreg_r;
		ser_nxt      = ser_r;
		push         = 1'b0;
		pop          = 1'b0;
		ser_go       = 1'b0;
		ser_src      = head;
		start_fall   = prev_r.convert_start_n & ~pin_s.convert_start_n;
		rst_fall     = prev_r.dev_reset & ~pin_s.dev_reset;
		// a start is taken only when idle and the buffer has room
		start_ok     = start_fall && ctl_r == CT_IDLE && fill_r != 2'h2 && !pin_s.dev_reset;
		// conversion and busy sequencing
		unique case (ctl_r)
			CT_IDLE: begin
				if (start_ok) begin
					ctl_nxt  = CT_CONV;
					busy_nxt = 1'b1;
					cnt_nxt  = 7'h00;
				end
			end
			CT_CONV: begin
				cnt_nxt = cnt_r + 7'h01;
				if (cnt_r == CONV_END) begin
					push    = 1'b1;
					ctl_nxt = CT_HOLD;
				end
			end
			CT_HOLD: begin
				cnt_nxt = cnt_r + 7'h01;
				if (is_rac(pin_s.mode)) begin
					ctl_nxt = CT_SERBUSY;
				end else begin
					busy_nxt = 1'b0;
					ctl_nxt  = CT_IDLE;
				end
			end
			CT_SERBUSY: begin
				cnt_nxt = cnt_r + 7'h01;
				// end of frame, or the longest busy for this divider
				if (!ser_r.frame_sync ||
					cnt_r >= rac_busy_cyc(pin_s.serial_clock_divider) - 7'h01) begin
					busy_nxt = 1'b0;
					ctl_nxt  = CT_IDLE;
				end
			end
			CT_RSTBUSY: begin
				cnt_nxt = cnt_r + 7'h01;
				if (cnt_r == RST_END) begin
					busy_nxt = 1'b0;
					ctl_nxt  = CT_IDLE;
				end
			end
			default: ctl_nxt = CT_IDLE;
		endcase
		// parallel port: fresh result loads ahead of busy falling, request drives head
		par_oe_n_nxt = pin_s.bus_req_n | is_serial(pin_s.mode);
		if (push && !is_serial(pin_s.mode)) begin
			par_data_nxt = sar_result;
		end else if (!pin_s.bus_req_n && fill_r != 2'h0) begin
			par_data_nxt = head;
		end
		if (!is_serial(pin_s.mode) && !prev_r.bus_req_n && pin_s.bus_req_n && fill_r != 2'h0) begin
			pop = 1'b1;
		end
		// serial master: data driver follows chip select
		ser_nxt.sdo_oe_n = pin_s.chip_select_n | ~is_serial(pin_s.mode);
		unique case (ser_st_r)
			SR_IDLE: begin
				if (start_ok && pin_s.mode == MODE_SER_RDC && fill_r != 2'h0) begin
					ser_st_nxt = SR_WAIT;
					scnt_nxt   = 5'h00;
				end
			end
			SR_WAIT: begin
				scnt_nxt = scnt_r + 5'h01;
				if (scnt_r == RDC_END) begin
					ser_go = 1'b1;
				end
			end
			SR_SHIFT: begin
				hcnt_nxt = hcnt_r + 3'h1;
				if (hcnt_r == sclk_half(pin_s.serial_clock_divider) - 3'h1) begin
					hcnt_nxt             = 3'h0;
					ser_nxt.serial_clock = ~ser_r.serial_clock;
					if (ser_r.serial_clock) begin
						if (scnt_r == BIT_END) begin
							ser_nxt.frame_sync = 1'b0;
							ser_st_nxt         = SR_IDLE;
							pop                = 1'b1;
						end else begin
							scnt_nxt  = scnt_r + 5'h01;
							shreg_nxt = {shreg_r[W-2:0], 1'b0};
						end
					end
				end
			end
			default: ser_st_nxt = SR_IDLE;
		endcase
		// read-after-convert starts the frame with the result as it is stored
		rac_go = push && is_rac(pin_s.mode) && ser_st_r == SR_IDLE;
		if (rac_go) begin
			ser_go  = 1'b1;
			ser_src = sar_result;
		end
		if (ser_go) begin
			ser_st_nxt           = SR_SHIFT;
			ser_nxt.frame_sync   = 1'b1;
			ser_nxt.serial_clock = 1'b0;
			shreg_nxt            = ser_src;
			scnt_nxt             = 5'h00;
			hcnt_nxt             = 3'h0;
		end
		// two-entry result buffer; a full buffer refuses new starts
		if (push) begin
			buf_nxt[wp_r] = sar_result;
			wp_nxt        = ~wp_r;
		end
		if (pop) begin
			rp_nxt = ~rp_r;
		end
		fill_nxt = 2'(fill_r + {1'b0, push} - {1'b0, pop});
		// reset pin aborts conversion, busy, serial frame and buffer, its release starts a busy interval
		if (pin_s.dev_reset) begin
			ctl_nxt            = CT_IDLE;
			busy_nxt           = 1'b0;
			ser_st_nxt         = SR_IDLE;
			ser_nxt.frame_sync = 1'b0;
			fill_nxt           = 2'h0;
			rp_nxt             = wp_r;
			wp_nxt             = wp_r;
		end else if (rst_fall) begin
			ctl_nxt  = CT_RSTBUSY;
			busy_nxt = 1'b1;
			cnt_nxt  = 7'h00;
		end
		ser_nxt.serial_data_out = shreg_nxt[W-1];
	end

	// registers of the whole block
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			ctl_r      <= CT_IDLE;
			cnt_r      <= 7'h00;
			busy_r     <= 1'b0;
			prev_r     <= adcrt_pins_t'(PIN_RST);
			buf_r[0]   <= '0;
			buf_r[1]   <= '0;
			wp_r       <= 1'b0;
			rp_r       <= 1'b0;
			fill_r     <= 2'h0;
			par_data_r <= '0;
			par_oe_n_r <= 1'b1;
			ser_st_r   <= SR_IDLE;
			scnt_r     <= 5'h00;
			hcnt_r     <= 3'h0;
			shreg_r    <= '0;
			ser_r      <= 4'h1;
		end else if (clk_en) begin
			ctl_r      <= ctl_nxt;
			cnt_r      <= cnt_nxt;
			busy_r     <= busy_nxt;
			prev_r     <= prev_nxt;
			buf_r      <= buf_nxt;
			wp_r       <= wp_nxt;
			rp_r       <= rp_nxt;
			fill_r     <= fill_nxt;
			par_data_r <= par_data_nxt;
			par_oe_n_r <= par_oe_n_nxt;
			ser_st_r   <= ser_st_nxt;
			scnt_r     <= scnt_nxt;
			hcnt_r     <= hcnt_nxt;
			shreg_r    <= shreg_nxt;
			ser_r      <= ser_nxt;
		end
	end

	// run length of busy, so interval checks need no long repetition
	logic [6:0] busy_len_r, busy_len_nxt;
	always_comb begin
		busy_len_nxt = 7'h00;
		if (busy_r) begin
			busy_len_nxt = (busy_len_r == 7'h7f) ? busy_len_r : busy_len_r + 7'h01;
		end
	end
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			busy_len_r <= 7'h00;
		end else if (clk_en) begin
			busy_len_r <= busy_len_nxt;
		end
	end

	// checks, all on clock while enabled
	default clocking cb @(posedge clock iff clk_en); endclocking
	default disable iff (!rst_n);

	// busy low again after exactly twelve high cycles
	sequence s_busy_conv;
		##12 (!busy_r && busy_len_r == 7'h0c);
	endsequence

	a_busy_rise: assert property (start_ok |=> busy_r)
		else $error("busy did not rise after start");
	a_busy_width: assert property (start_ok && !is_rac(pin_s.mode) && !pin_s.dev_reset
		|=> s_busy_conv) else $error("busy width wrong");
	a_eoc_gap: assert property (push |=> busy_r)
		else $error("busy fell with conversion end");
	a_data_lead: assert property (push && !is_serial(pin_s.mode)
		|=> (par_data_r == $past(sar_result) && busy_r) ##1 !busy_r)
		else $error("parallel data not ahead of busy");
	a_bus_drive: assert property ($fell(pin_s.bus_req_n) && !is_serial(pin_s.mode)
		&& fill_r != 2'h0 && !push |=> !par_oe_n_r && par_data_r == $past(head))
		else $error("bus data not driven");
	a_rst_busy: assert property (rst_fall |=> s_busy_conv)
		else $error("reset busy interval wrong");
	a_sync_rdc: assert property (start_ok && pin_s.mode == MODE_SER_RDC && fill_r != 2'h0
		&& ser_st_r == SR_IDLE |-> ##3 $rose(ser_r.frame_sync))
		else $error("frame sync late in read during convert");
	a_sync_rac: assert property (rac_go |=> $rose(ser_r.frame_sync))
		else $error("frame sync late in read after convert");
	a_busy_after_fs: assert property (ctl_r == CT_SERBUSY && $fell(ser_r.frame_sync)
		|=> $fell(busy_r)) else $error("busy did not follow frame sync");
	a_sclk_toggle: assert property (ser_st_r == SR_SHIFT && $rose(ser_r.serial_clock)
		|=> !ser_r.serial_clock) else $error("serial clock high too long");
	a_rac_limit: assert property (ctl_r == CT_SERBUSY
		|-> cnt_r < rac_busy_cyc(pin_s.serial_clock_divider))
		else $error("read after convert busy too long");
	a_sdo_enable: assert property ($changed(pin_s.chip_select_n) && is_serial(pin_s.mode)
		|=> ser_r.sdo_oe_n == $past(pin_s.chip_select_n))
		else $error("serial data enable wrong");
endmodule

// file: adcrt_consts.svh
// adcrt_consts.svh - timing counts, widths and reset values of the converter control block
// assumes a 25 MHz system clock; included by the package and the top module
`ifndef ADCRT_CONSTS_SVH
`define ADCRT_CONSTS_SVH
`define ADCRT_CLK_NS            40
`define ADCRT_RES_W             18
`define ADCRT_PIN_RST           8'h70
`define ADCRT_FLOOR1(t)         (((t) / `ADCRT_CLK_NS) < 1 ? 1 : ((t) / `ADCRT_CLK_NS))
`define ADCRT_CEIL1(t)          ((((t) + `ADCRT_CLK_NS - 1) / `ADCRT_CLK_NS) < 1 ? 1 : \
                                 (((t) + `ADCRT_CLK_NS - 1) / `ADCRT_CLK_NS))
`define ADCRT_T_BUSY_RISE_NS    23
`define ADCRT_BUSY_RISE_CYC     `ADCRT_FLOOR1(`ADCRT_T_BUSY_RISE_NS)
`define ADCRT_T_BUSY_NS         550
`define ADCRT_BUSY_CYC          `ADCRT_FLOOR1(`ADCRT_T_BUSY_NS)
`define ADCRT_T_EOC_GAP_NS      10
`define ADCRT_EOC_GAP_CYC       `ADCRT_CEIL1(`ADCRT_T_EOC_GAP_NS)
`define ADCRT_T_RST_BUSY_NS     500
`define ADCRT_RST_BUSY_CYC      `ADCRT_FLOOR1(`ADCRT_T_RST_BUSY_NS)
`define ADCRT_T_SYNC_RDC_NS     135
`define ADCRT_SYNC_RDC_CYC      `ADCRT_FLOOR1(`ADCRT_T_SYNC_RDC_NS)
`define ADCRT_SCLK_MIN0_NS      8
`define ADCRT_SCLK_MIN1_NS      16
`define ADCRT_SCLK_MIN2_NS      32
`define ADCRT_SCLK_MIN3_NS      64
`define ADCRT_RAC_BUSY0_NS      840
`define ADCRT_RAC_BUSY1_NS      1140
`define ADCRT_RAC_BUSY2_NS      1720
`define ADCRT_RAC_BUSY3_NS      2880
`endif

// file: adcrt_pkg.sv
// adcrt_pkg.sv - types and decode functions of the converter control block
// assumes adcrt_consts.svh is on the include path
`include "adcrt_consts.svh"
package adcrt_pkg;
	typedef enum logic [1:0] {MODE_PAR_A, MODE_PAR_B, MODE_SER_RDC, MODE_SER_RAC} adcrt_mode_t;
	typedef enum logic [2:0] {CT_IDLE, CT_CONV, CT_HOLD, CT_SERBUSY, CT_RSTBUSY} adcrt_ctl_t;
	typedef enum logic [1:0] {SR_IDLE, SR_WAIT, SR_SHIFT} adcrt_srst_t;
	typedef logic [`ADCRT_RES_W-1:0] adcrt_word_t;
	// synchronised pin group, msb first as packed on the ports
	typedef struct packed {
		logic        dev_reset;
		logic        convert_start_n;
		logic        chip_select_n;
		logic        bus_req_n;
		adcrt_mode_t mode;
		logic [1:0]  serial_clock_divider;
	} adcrt_pins_t;
	// serial master outputs
	typedef struct packed {
		logic frame_sync;
		logic serial_clock;
		logic serial_data_out;
		logic sdo_oe_n;
	} adcrt_ser_t;
	// mode decodes
	function automatic logic is_serial(input adcrt_mode_t m);
		return m[1];
	endfunction
	function automatic logic is_rac(input adcrt_mode_t m);
		return m == MODE_SER_RAC;
	endfunction
	// serial clock half period in cycles for a divider setting
	function automatic logic [2:0] sclk_half(input logic [1:0] d);
		unique case (d)
			2'h0: return 3'(`ADCRT_CEIL1(`ADCRT_SCLK_MIN0_NS / 2));
			2'h1: return 3'(`ADCRT_CEIL1(`ADCRT_SCLK_MIN1_NS / 2));
			2'h2: return 3'(`ADCRT_CEIL1(`ADCRT_SCLK_MIN2_NS / 2));
			2'h3: return 3'(`ADCRT_CEIL1(`ADCRT_SCLK_MIN3_NS / 2));
		endcase
	endfunction
	// longest busy in read-after-convert mode, in cycles
	function automatic logic [6:0] rac_busy_cyc(input logic [1:0] d);
		unique case (d)
			2'h0: return 7'(`ADCRT_FLOOR1(`ADCRT_RAC_BUSY0_NS));
			2'h1: return 7'(`ADCRT_FLOOR1(`ADCRT_RAC_BUSY1_NS));
			2'h2: return 7'(`ADCRT_FLOOR1(`ADCRT_RAC_BUSY2_NS));
			2'h3: return 7'(`ADCRT_FLOOR1(`ADCRT_RAC_BUSY3_NS));
		endcase
	endfunction
endpackage

// file: adcrt_host.sv
// adcrt_host.sv - host model: starts conversions, pulses device reset, reads the parallel port
// assumes the bench calls its tasks; waits that run out are counted in fails, except the wait for the port to drive
`timescale 1ns/1ps
module adcrt_host
	import adcrt_pkg::*;
(
	// clock and status from the device
	input  wire logic        clock,
	input  wire logic        busy,
	input  wire logic        par_oe_n,
	input  wire adcrt_word_t par_data,
	// host pins
	output logic             convert_start_n,
	output logic             bus_req_n,
	output logic             chip_select_n,
	output logic             dev_reset
);
	realtime t_last = -1000.0;
	int      fails  = 0;
	// idle pin levels from time zero
	initial begin
		convert_start_n = 1'b1;
		bus_req_n = 1'b1;
		chip_select_n = 1'b1;
		dev_reset = 1'b0;
	end
	// wait for busy low, acquisition and spacing, then one start pulse
	task automatic convert();
		int n;
		n = 0;
		while (busy !== 1'b0 && n < 200) begin
			@(posedge clock);
			n++;
		end
		if (n == 200) fails++;
		repeat (7) @(posedge clock);
		while ($realtime - t_last < 800.0) @(posedge clock);
		convert_start_n <= 1'b0;
		t_last = $realtime;
		@(posedge clock);
		convert_start_n <= 1'b1;
	endtask
	// hold the request until the port drives, take the word, then release
	task automatic read_par(output adcrt_word_t w);
		int n;
		bus_req_n <= 1'b0;
		n = 0;
		do begin
			@(posedge clock);
			n++;
		end while (par_oe_n !== 1'b0 && n < 10);
		w = par_data;
		bus_req_n <= 1'b1;
		do begin
			@(posedge clock);
			n++;
		end while (par_oe_n !== 1'b1 && n < 20);
		if (n >= 20) fails++;
	endtask
	// one-cycle pulse on the device reset pin
	task automatic reset_pulse();
		dev_reset <= 1'b1;
		@(posedge clock);
		dev_reset <= 1'b0;
	endtask
	// chip select level
	task automatic select(input logic lvl);
		chip_select_n <= lvl;
	endtask
endmodule

// file: test_adc_conversion_readout_timing.sv
// test_adc_conversion_readout_timing.sv - self-checking bench of the converter control block
// assumes adcrt_host.sv as host model; the bench plays the conversion core
`timescale 1ns/1ps
module test_adc_conversion_readout_timing
	import adcrt_pkg::*;
;
	logic        clock;
	logic        rst_n;
	logic        clk_en;
	logic [1:0]  mode;
	logic [1:0]  serial_clock_divider;
	adcrt_word_t sar_result;
	logic        busy;
	adcrt_word_t par_data;
	logic        par_oe_n;
	adcrt_ser_t  serial_port;
	wire logic   convert_start_n;
	wire logic   bus_req_n;
	wire logic   chip_select_n;
	wire logic   dev_reset;
	int          bad_count = 0;
	int          n_checks  = 0;
	// block under test and host model
	adcrt_top u_adcrt_top (.clock(clock), .rst_n(rst_n), .clk_en(clk_en),
		.convert_start_n(convert_start_n), .dev_reset(dev_reset),
		.chip_select_n(chip_select_n), .bus_req_n(bus_req_n), .mode(mode),
		.serial_clock_divider(serial_clock_divider), .sar_result(sar_result), .busy(busy),
		.par_data(par_data), .par_oe_n(par_oe_n), .serial_port(serial_port));
	adcrt_host u_adcrt_host (.clock(clock), .busy(busy), .par_oe_n(par_oe_n),
		.par_data(par_data), .convert_start_n(convert_start_n), .bus_req_n(bus_req_n),
		.chip_select_n(chip_select_n), .dev_reset(dev_reset));
	// 25 MHz clock
	always #20 clock = ~clock;
	// compare design values and counts
	task automatic cmp_val(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic cmp_cnt(input int got, input int exp);
		cmp_val(got, exp);
	endtask
	// print counts and verdict, then stop
	task automatic give_verdict();
		bad_count += u_adcrt_host.fails;
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	// cycles to busy rising, cycles busy high, parallel data as busy falls
	task automatic watch_busy(output int rise, output int high, output adcrt_word_t d);
		rise = 0;
		high = 0;
		while (busy !== 1'b1 && rise < 20) begin
			@(posedge clock);
			#1 rise++;
		end
		while (busy === 1'b1 && high < 100) begin
			@(posedge clock);
			#1 high++;
		end
		d = par_data;
		@(posedge clock);
	endtask
	// collect one serial frame: word, busy-to-sync cycles, clock period, busy cycles
	task automatic grab(output adcrt_word_t got, output int fs_rel, output int per,
		output int hi);
		int   n;
		int   bits;
		int   rb;
		int   last;
		logic prev;
		got = '0;
		{n, bits, rb, last, fs_rel, per, hi} = '0;
		prev = 1'b0;
		while (n < 150 && !(bits == 18 && serial_port.frame_sync === 1'b0)) begin
			@(posedge clock);
			#1 n++;
			if (busy === 1'b1 && rb == 0) rb = n;
			if (busy === 1'b1) hi++;
			if (serial_port.frame_sync === 1'b1 && fs_rel == 0) fs_rel = n - rb;
			if (serial_port.serial_clock === 1'b1 && prev === 1'b0) begin
				got = {got[16:0], serial_port.serial_data_out};
				bits++;
				per = n - last;
				last = n;
			end
			prev = serial_port.serial_clock;
		end
		while (busy === 1'b1 && n < 300) begin
			@(posedge clock);
			#1 n++;
			if (busy === 1'b1) hi++;
		end
		@(posedge clock);
	endtask
	// outputs while reset is held
	task automatic t_reset();
		cmp_val(busy, 1'b0);
		cmp_val(par_oe_n, 1'b1);
		cmp_val(serial_port, 4'h1);
		$display("test reset done");
	endtask
	// two parallel conversions fill the buffer, a third is refused, then both read
	task automatic t_parallel();
		int          rise;
		int          high;
		adcrt_word_t d;
		mode <= 2'h0;
		sar_result <= 18'h2a5c3;
		u_adcrt_host.convert();
		watch_busy(rise, high, d);
		cmp_cnt(rise <= 4, 1);
		cmp_cnt(high, 12);
		cmp_val(d, 18'h2a5c3);
		mode <= 2'h1;
		sar_result <= 18'h15a3c;
		u_adcrt_host.convert();
		watch_busy(rise, high, d);
		cmp_cnt(high, 12);
		u_adcrt_host.convert();
		watch_busy(rise, high, d);
		cmp_cnt(high, 0); // full buffer ignores the start
		u_adcrt_host.read_par(d);
		cmp_val(d, 18'h2a5c3);
		u_adcrt_host.read_par(d);
		cmp_val(d, 18'h15a3c);
		$display("test parallel done");
	endtask
	// device reset pin forces a busy interval
	task automatic t_devreset();
		int          rise;
		int          high;
		adcrt_word_t d;
		u_adcrt_host.reset_pulse();
		watch_busy(rise, high, d);
		cmp_cnt(rise <= 4, 1);
		cmp_cnt(high, 12);
		$display("test device reset done");
	endtask
	// chip select drives or releases the serial data output
	task automatic t_cs(input logic lvl);
		mode <= 2'h2;
		u_adcrt_host.select(lvl);
		repeat (4) @(posedge clock);
		#1 cmp_val(serial_port.sdo_oe_n, lvl);
		@(posedge clock);
		$display("test chip select done");
	endtask
	// read-after-convert frames for every divider setting
	task automatic t_serial_rac();
		int          rac_ns[4] = '{840, 1140, 1720, 2880};
		adcrt_word_t got;
		int          fs_rel;
		int          per;
		int          hi;
		int          lim;
		mode <= 2'h3;
		for (int k = 0; k < 4; k++) begin
			serial_clock_divider <= 2'(k);
			sar_result <= 18'h3c0f5 ^ 18'(k);
			u_adcrt_host.convert();
			grab(got, fs_rel, per, hi);
			lim = rac_ns[k] / 40;
			cmp_val(got, 18'h3c0f5 ^ 18'(k));
			cmp_cnt(fs_rel, 11);
			cmp_cnt(per, 2);
			cmp_cnt(hi, lim < 48 ? lim : 48);
		end
		$display("test read after convert done");
	endtask
	// read-during-convert sends the stored word while the next one converts
	task automatic t_serial_rdc();
		adcrt_word_t got;
		int          fs_rel;
		int          per;
		int          hi;
		mode <= 2'h2;
		sar_result <= 18'h0b7e1;
		u_adcrt_host.convert();
		watch_busy(fs_rel, hi, got);
		sar_result <= 18'h2d418;
		u_adcrt_host.convert();
		grab(got, fs_rel, per, hi);
		cmp_val(got, 18'h0b7e1);
		cmp_cnt(fs_rel, 2);
		cmp_cnt(hi, 12);
		$display("test read during convert done");
	endtask
	// main sequence
	initial begin
		clock = 1'b0;
		rst_n = 1'b0;
		clk_en = 1'b1;
		mode = 2'h0;
		serial_clock_divider = 2'h0;
		sar_result = '0;
		repeat (6) @(posedge clock);
		t_reset();
		rst_n <= 1'b1;
		t_parallel();
		t_devreset();
		t_cs(1'b0);
		t_serial_rac();
		t_serial_rdc();
		t_cs(1'b1);
		give_verdict();
	end
	// cut a hang short
	initial begin
		repeat (20000) @(posedge clock);
		bad_count++;
		give_verdict();
	end
endmodule
